// file: design/omc_map.svh
// Constants for the operating mode controller: startup codes and encodings.
// Assumes inclusion by the package and the controller module only.
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH

// Startup setting codes, held as 16-bit BCD-style words.
`define OMC_SU_SWITCH    16'h0000
`define OMC_SU_RESUME    16'h0100
`define OMC_SU_FIX_EDIT  16'h0200
`define OMC_SU_FIX_MON   16'h0201
`define OMC_SU_FIX_RUN   16'h0202
`define OMC_SU_DEFAULT   16'h0000

// Operating mode encodings.
`define OMC_MODE_EDIT    2'h0
`define OMC_MODE_MON     2'h1
`define OMC_MODE_RUN     2'h2

`endif

// file: design/omc_pkg.sv
// Types shared by the operating mode controller and its bench.
// Assumes omc_map.svh is on the include path.
`include "omc_map.svh"

package omc_pkg;

    // Operating mode of the controller.
    typedef enum logic [1:0] {
        OMC_EDIT = `OMC_MODE_EDIT,
        OMC_MON  = `OMC_MODE_MON,
        OMC_RUN  = `OMC_MODE_RUN
    } omc_mode_t;

    // Console key strobes, each a one-cycle pulse.
    typedef struct packed {
        logic clear;
        logic shift;
        logic aux_hold;
        logic other;
    } omc_keys_t;

    // Permission flags derived from the mode.
    typedef struct packed {
        logic exec;
        logic io_refresh;
        logic force_ok;
        logic value_ok;
        logic edit_ok;
        logic status_ok;
    } omc_perm_t;

endpackage : omc_pkg

// file: design/omc_ctrl.sv
// Operating mode controller: startup mode choice, mode permissions,
// mode-change display, shift latch and area key selection.
// Assumes key strobes are clean pulses from same-clock logic; console
// presence, device presence and mode switch arrive from pins.
//
// Summary of operation
// - Code 0000 with console follows mode switch.
// - Code 0000, no console: run or editing.
// - Code 0100 resumes mode held at power loss.
// - Codes 0200/0201/0202 start in editing/monitor/run; a later switch turn still changes mode.
// - Startup setting defaults to 0000.
// - Editing mode never executes the program.
// - Monitor mode executes and allows forcing/edits.
// - Run mode permits monitoring, rejects forcing/values.
// - Mode display blocks keys until clear key.
// - Shift during switch turn suppresses display.
// - Shift press toggles latch with indicator.
// - Latched shift picks aux area, else hold.
`timescale 1ns/1ps
`default_nettype none
`include "omc_map.svh"

module omc_ctrl (
    input  wire logic               i_sys_clk,       // 40 MHz clock.
    input  wire logic               i_sys_rst,       // Power-on reset.
    input  wire logic [15:0]        i_startup_mode_setting, // Stored code.
    input  wire logic               i_setting_valid, // Code has been loaded.
    input  wire logic [1:0]         i_retained_mode, // Mode kept at loss.
    input  wire logic               i_console_present, // Pin, async.
    input  wire logic               i_other_device,  // Pin, async.
    input  wire logic [1:0]         i_mode_switch,   // Pin, async.
    input  wire omc_pkg::omc_keys_t i_keys,          // Key strobes.
    output logic [1:0]              o_mode,          // Current mode.
    output var omc_pkg::omc_perm_t  o_perm,          // Mode permissions.
    output logic                    o_mode_display,  // Mode name shown.
    output logic                    o_shift_ind,     // Shift indicator.
    output logic                    o_area_aux,      // Area pick is aux.
    output logic                    o_area_strobe,   // Area pick valid.
    output logic                    o_key_accept,    // Non-mode key taken.
    output logic [1:0]              o_retain_mode,   // Mode to keep.
    output logic                    o_retain_we,     // Write retained.
    output logic                    o_started        // Startup done.
);
    import omc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [1:0] sync_pres_a;  // Presence pins, first stage.
    logic [1:0] sync_pres_b;  // Presence pins, second stage.
    logic [1:0] sync_sw_a;    // Mode switch, first stage.
    logic [1:0] sync_sw_b;    // Mode switch, second stage.
    logic [1:0] sw_last;      // Switch value seen last cycle.

    // Two stages each; only the second stage is read by logic.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync_pres_a <= 2'h0;
            sync_pres_b <= 2'h0;
            sync_sw_a   <= `OMC_MODE_EDIT;
            sync_sw_b   <= `OMC_MODE_EDIT;
            sw_last     <= `OMC_MODE_EDIT;
        end else begin
            sync_pres_a <= {i_console_present, i_other_device};
            sync_pres_b <= sync_pres_a;
            sync_sw_a   <= i_mode_switch;
            sync_sw_b   <= sync_sw_a;
            sw_last     <= sync_sw_b;
        end
    end

    wire logic console = sync_pres_b[1];
    wire logic other   = sync_pres_b[0];

    // Map a raw two-bit switch code onto a legal mode; an unused code
    // is treated as editing mode, the safe choice.
    function automatic logic [1:0] legal_mode(input logic [1:0] m);
        case (m)
            `OMC_MODE_MON: legal_mode = `OMC_MODE_MON;
            `OMC_MODE_RUN: legal_mode = `OMC_MODE_RUN;
            default:       legal_mode = `OMC_MODE_EDIT;
        endcase
    endfunction : legal_mode

    ////////////////////////////////////////////////////////////////////////
    // Startup choice and mode register.

    typedef enum logic [1:0] {
        ST_WAIT   = 2'b00,
        ST_SETTLE = 2'b01,
        ST_ACTIVE = 2'b10
    } omc_state_t;

    omc_state_t state;        // Startup sequencer.
    omc_state_t next_state;
    logic [1:0] mode;         // Current operating mode.
    logic [1:0] next_mode;
    logic       retain_we;
    logic       next_retain_we;
    logic       sw_change;    // Switch turned while active.
    logic       started;      // Startup choice made, kept in a flop.
    logic       next_started;

    assign sw_change = (state == ST_ACTIVE) && (sync_sw_b != sw_last)
                       && console;

    // The settle state waits for the synchronisers to carry real pin
    // levels before the startup choice is made.
    always_comb begin
        next_state     = state;
        next_mode      = mode;
        next_retain_we = 1'b0;
        case (state)
            ST_WAIT: begin
                if (i_setting_valid) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                next_state     = ST_ACTIVE;
                next_retain_we = 1'b1;
                case (i_startup_mode_setting)
                    `OMC_SU_RESUME: begin
                        next_mode = legal_mode(i_retained_mode);
                    end
                    `OMC_SU_FIX_EDIT: next_mode = `OMC_MODE_EDIT;
                    `OMC_SU_FIX_MON:  next_mode = `OMC_MODE_MON;
                    `OMC_SU_FIX_RUN:  next_mode = `OMC_MODE_RUN;
                    default: begin
                        // Code 0000 and unknown codes behave alike.
                        if (console) begin
                            next_mode = legal_mode(sync_sw_b);
                        end else if (other) begin
                            next_mode = `OMC_MODE_EDIT;
                        end else begin
                            next_mode = `OMC_MODE_RUN;
                        end
                    end
                endcase
            end
            ST_ACTIVE: begin
                if (sw_change) begin
                    next_mode      = legal_mode(sync_sw_b);
                    next_retain_we = 1'b1;
                end
            end
            default: begin
                next_state = ST_WAIT;
            end
        endcase
        // Registered so the started output comes straight from a flop.
        next_started = (next_state == ST_ACTIVE);
    end

    // Reset parks the controller in editing mode, so nothing runs
    // before the startup choice is made.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state     <= ST_WAIT;
            mode      <= `OMC_MODE_EDIT;
            retain_we <= 1'b0;
            started   <= 1'b0;
        end else begin
            state     <= next_state;
            mode      <= next_mode;
            retain_we <= next_retain_we;
            started   <= next_started;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Console display, shift latch and key handling.

    logic disp;        // Mode name on screen.
    logic next_disp;
    logic shift;       // Shift latched.
    logic next_shift;
    logic aux;         // Area pick.
    logic next_aux;
    logic area_stb;
    logic next_area_stb;
    logic accept;
    logic next_accept;
    logic keys_free;   // Keys may act this cycle.

    assign keys_free = (state == ST_ACTIVE) && !disp;

    // A switch turn sets the display unless shift is held, and the set
    // wins over a clear arriving in the same cycle.
    always_comb begin
        next_disp     = disp;
        next_shift    = shift;
        next_aux      = aux;
        next_area_stb = 1'b0;
        next_accept   = 1'b0;
        if (disp && i_keys.clear) begin
            next_disp = 1'b0;
        end
        if (sw_change && !shift) begin
            next_disp = 1'b1;
        end
        if (keys_free) begin
            if (i_keys.shift) begin
                next_shift = !shift;
            end else if (i_keys.aux_hold) begin
                next_aux      = shift;
                next_area_stb = 1'b1;
                next_accept   = 1'b1;
                next_shift    = 1'b0;
            end else if (i_keys.other || i_keys.clear) begin
                next_accept = 1'b1;
                next_shift  = 1'b0;
            end
        end
    end

    // Holds the console-facing state.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            disp     <= 1'b0;
            shift    <= 1'b0;
            aux      <= 1'b0;
            area_stb <= 1'b0;
            accept   <= 1'b0;
        end else begin
            disp     <= next_disp;
            shift    <= next_shift;
            aux      <= next_aux;
            area_stb <= next_area_stb;
            accept   <= next_accept;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    omc_perm_t next_perm;

    // Permissions follow the mode of the next cycle so they align with
    // the registered mode output.
    always_comb begin
        next_perm = '0;
        case (next_mode)
            `OMC_MODE_MON: begin
                next_perm = 6'h3f;
            end
            `OMC_MODE_RUN: begin
                next_perm.exec       = 1'b1;
                next_perm.io_refresh = 1'b1;
                next_perm.status_ok  = 1'b1;
            end
            default: begin
                next_perm.edit_ok   = 1'b1;
                next_perm.status_ok = 1'b1;
            end
        endcase
        if (next_state != ST_ACTIVE) begin
            next_perm = '0;
        end
    end

    // Output flops; the retained-mode port mirrors the mode register.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_perm <= '0;
        end else begin
            o_perm <= next_perm;
        end
    end

    always_comb o_mode         = mode;
    always_comb o_retain_mode  = mode;
    always_comb o_retain_we    = retain_we;
    always_comb o_mode_display = disp;
    always_comb o_shift_ind    = shift;
    always_comb o_area_aux     = aux;
    always_comb o_area_strobe  = area_stb;
    always_comb o_key_accept   = accept;
    always_comb o_started      = started;

endmodule : omc_ctrl
`default_nettype wire

// file: test/omc_monitor.sv
// Port checker for the operating mode controller.
// Assumes a bind from the bench top file; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module omc_monitor (
    input wire logic               i_sys_clk,
    input wire logic               i_sys_rst,
    input wire omc_pkg::omc_keys_t i_keys,
    input wire logic               i_console_present,
    input wire logic [1:0]         o_mode,
    input wire omc_pkg::omc_perm_t o_perm,
    input wire logic               o_mode_display,
    input wire logic               o_shift_ind,
    input wire logic               o_area_aux,
    input wire logic               o_area_strobe,
    input wire logic [1:0]         o_retain_mode,
    input wire logic               o_retain_we,
    input wire logic               o_started
);
    import omc_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////////////
    // Nothing may run before the startup choice is made.
    AST_PERM_IDLE: assert property (!o_started |-> o_perm == '0)
        else $error("permissions set before startup");
    AST_EXEC: assert property (o_started |->
        o_perm.exec == (o_mode != OMC_EDIT))
        else $error("execute flag does not follow mode");
    AST_FORCE: assert property (o_started |->
        o_perm.force_ok == (o_mode == OMC_MON))
        else $error("force flag does not follow mode");
    AST_VALUE: assert property (o_started |->
        o_perm.value_ok == (o_mode == OMC_MON))
        else $error("value change flag does not follow mode");
    AST_RETAIN: assert property (o_retain_mode == o_mode)
        else $error("retained mode differs from mode");
    AST_RETAIN_WE: assert property ($rose(o_started) |-> o_retain_we)
        else $error("no store write at startup");
    // A mode change in service must reach the store in the same cycle.
    AST_STORE_CHG: assert property ($past(o_started) &&
        o_mode != $past(o_mode) |-> o_retain_we)
        else $error("mode change not written to store");
    // Keys other than clear are dropped while the mode name shows.
    AST_BLOCK: assert property (o_mode_display && i_keys == 4'h2
        |=> !o_area_strobe)
        else $error("area key taken under mode display");
    AST_DISP: assert property ($past(o_started) &&
        !$past(o_shift_ind) && o_mode != $past(o_mode) |-> o_mode_display)
        else $error("mode change without mode display");
    AST_SHIFT: assert property (o_started && !o_mode_display &&
        i_keys == 4'h4 |=> o_shift_ind != $past(o_shift_ind))
        else $error("shift press did not toggle latch");
    AST_AREA: assert property (o_area_strobe |->
        o_area_aux == $past(o_shift_ind))
        else $error("area pick does not follow shift latch");
    AST_HOLD: assert property (o_started && $past(o_started) &&
        !i_console_present |-> $stable(o_mode))
        else $error("mode moved without console");
    cover property (o_mode_display);
    cover property (o_area_strobe && o_area_aux);
    cover property ($rose(o_started) && o_mode == OMC_MON);
endmodule : omc_monitor
`default_nettype wire

// file: test/omc_console.sv
// Behavioural handheld console: presence pin, mode switch, keypad.
// Assumes the bench calls its tasks; keys change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module omc_console (
    input  wire logic              i_clk,
    output var omc_pkg::omc_keys_t o_keys,
    output logic                   o_present,
    output logic [1:0]             o_switch
);
    initial begin
        o_keys = '0;
        o_present = 1'b0;
        o_switch = 2'h0;
    end
    // A key is a one-cycle pulse, then one idle cycle at least.
    task automatic press(input logic [3:0] k);
        @(negedge i_clk);
        o_keys = k;
        @(negedge i_clk);
        o_keys = '0;
    endtask : press
    // Pins move together and then stay put.
    task automatic pins(input logic p, input logic [1:0] m);
        @(negedge i_clk);
        o_present = p;
        o_switch = m;
    endtask : pins
endmodule : omc_console
`default_nettype wire

// file: test/operating_mode_controller_tb.sv
// Bench for the mode controller with a console model and store.
// Assumes omc_pkg, omc_ctrl, omc_console and omc_monitor compiled.
`timescale 1ns/1ps
`default_nettype none
module operating_mode_controller_tb;
    import omc_pkg::*;
    logic sys_clk = 1'b0, sys_rst, valid, other, we, aux;
    logic started, disp, ind, strobe, acc;
    logic [15:0] setting;
    logic [1:0] nvm, mode, rmode, sw;
    omc_keys_t keys;
    omc_perm_t perm;
    logic present;
    int failures = 0, n_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    // Nonvolatile store keeps the mode across a power loss.
    always @(posedge sys_clk) if (we) nvm <= rmode;
    omc_console omc_console_i (.i_clk(sys_clk), .o_keys(keys),
        .o_present(present), .o_switch(sw));
    omc_ctrl omc_ctrl_i (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
        .i_startup_mode_setting(setting), .i_setting_valid(valid),
        .i_retained_mode(nvm), .i_console_present(present),
        .i_other_device(other), .i_mode_switch(sw), .i_keys(keys),
        .o_mode(mode), .o_perm(perm), .o_mode_display(disp),
        .o_shift_ind(ind), .o_area_aux(aux), .o_area_strobe(strobe),
        .o_key_accept(acc), .o_retain_mode(rmode), .o_retain_we(we),
        .o_started(started));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // Power up with given code and pins; pins settle before valid.
    task automatic boot(input logic [15:0] c, input logic p, o,
                        input logic [1:0] m);
        @(negedge sys_clk);
        sys_rst = 1;
        valid = 0;
        setting = c;
        other = o;
        omc_console_i.pins(p, m);
        repeat (16) @(negedge sys_clk);
        sys_rst = 0;
        repeat (4) @(negedge sys_clk);
        valid = 1;
        for (int k = 0; k < 20 && started !== 1'b1; k++)
            @(negedge sys_clk);
    endtask : boot
    // Mode plus execute, force and value flags: run forbids both.
    task automatic chk_mode(input logic [1:0] m);
        chk(mode, m);
        chk({perm.exec, perm.force_ok, perm.value_ok},
            m == OMC_MON ? 3'h7 : m == OMC_RUN ? 3'h4 : 3'h0);
    endtask : chk_mode
    task automatic t_startup;
        boot(16'h0000, 1, 0, OMC_MON); chk_mode(OMC_MON);
        boot(16'h0000, 0, 0, OMC_EDIT); chk_mode(OMC_RUN);
        boot(16'h0000, 0, 1, OMC_RUN); chk_mode(OMC_EDIT);
        boot(16'h0200, 1, 0, OMC_RUN); chk_mode(OMC_EDIT);
        boot(16'h0201, 1, 0, OMC_RUN); chk_mode(OMC_MON);
        boot(16'h0202, 1, 0, OMC_EDIT); chk_mode(OMC_RUN);
    endtask : t_startup
    task automatic t_resume;
        boot(16'h0000, 1, 0, OMC_EDIT);
        omc_console_i.pins(1, OMC_MON);
        repeat (6) @(negedge sys_clk);
        chk(nvm, OMC_MON);
        boot(16'h0100, 1, 0, OMC_RUN); chk_mode(OMC_MON);
    endtask : t_resume
    // Display blocks keys until clear, then area and shift keys.
    task automatic t_keys;
        boot(16'h0000, 1, 0, OMC_EDIT);
        omc_console_i.pins(1, OMC_RUN);
        repeat (6) @(negedge sys_clk);
        chk_mode(OMC_RUN);
        chk(disp, 1);
        omc_console_i.press(4'h2); chk({strobe, acc}, 2'h0);
        omc_console_i.press(4'h4); chk(ind, 0);
        omc_console_i.press(4'h8); chk({disp, acc}, 2'h0);
        omc_console_i.press(4'h2); chk({strobe, aux, acc}, 3'h5);
        omc_console_i.press(4'h4); chk(ind, 1);
        omc_console_i.press(4'h2); chk({strobe, aux, ind}, 3'h6);
        omc_console_i.press(4'h4);
        omc_console_i.press(4'h4); chk(ind, 0);
        omc_console_i.press(4'h4);
        omc_console_i.pins(1, OMC_MON);
        repeat (6) @(negedge sys_clk);
        chk({mode, disp, ind}, {OMC_MON, 2'h1});
        omc_console_i.press(4'h1); chk({acc, ind}, 2'h2);
    endtask : t_keys
    initial begin
        #200000;
        failures++;
        wrap_up;
    end
    initial begin
        sys_rst = 1'b1;
        valid   = 1'b0;
        other   = 1'b0;
        setting = 16'h0000;
        t_startup;
        t_resume;
        t_keys;
        wrap_up;
    end
endmodule : operating_mode_controller_tb
bind omc_ctrl omc_monitor omc_monitor_i (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_keys(i_keys),
    .i_console_present(i_console_present),
    .o_mode(o_mode),
    .o_perm(o_perm),
    .o_mode_display(o_mode_display),
    .o_shift_ind(o_shift_ind),
    .o_area_aux(o_area_aux),
    .o_area_strobe(o_area_strobe),
    .o_retain_mode(o_retain_mode),
    .o_retain_we(o_retain_we),
    .o_started(o_started));
`default_nettype wire
